// ---- core/emp_pkg.sv ----
// Shared constants and types of the second Ethernet port pin interface.
// Assumes a 20 MHz system clock and PHY-supplied link clocks.
package emp_pkg;

   // ==========================================================
   // Timing
   localparam int EMP_SYS_PERIOD_NS = 50;
   localparam int EMP_MDC_HALF_NS = 200;
   localparam int EMP_MDC_HALF_CYC =
      (EMP_MDC_HALF_NS + EMP_SYS_PERIOD_NS - 1) / EMP_SYS_PERIOD_NS;

   // ==========================================================
   // Data path shape
   localparam logic [2:0] EMP_MII_UNITS = 3'h2;
   localparam logic [2:0] EMP_RMII_UNITS = 3'h4;
   localparam int EMP_MGMT_FRAME_BITS = 64;
   localparam logic [3:0] EMP_NIBBLE_IDLE = 4'h0;
   localparam logic [7:0] EMP_BYTE_RESET = 8'h00;

   // ==========================================================
   // Receive hand-over word fields
   localparam int EMP_RXW_LAST = 10;
   localparam int EMP_RXW_CRC = 9;
   localparam int EMP_RXW_ALIGN = 8;

   typedef enum logic [1:0] {
      EMP_MGMT_IDLE = 2'b00,
      EMP_MGMT_LOW = 2'b01,
      EMP_MGMT_HIGH = 2'b11
   } emp_mgmt_state_type;

endpackage

// ---- core/emp_mgmt.sv ----
// Management clock and data shifter for the second Ethernet port.
// Assumes the frame content is built by software; this only clocks bits.
module emp_mgmt
   import emp_pkg::*;
#(
   parameter int FRAME_BITS = EMP_MGMT_FRAME_BITS,
   parameter int HALF_CYC = EMP_MDC_HALF_CYC
) (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic mgmt_start,
   input wire logic [FRAME_BITS-1:0] mgmt_frame,
   input wire logic [6:0] mgmt_drive_bits,
   output logic mgmt_busy,
   output logic mgmt_done,
   output logic [FRAME_BITS-1:0] mgmt_read_word,
   output logic port1_mgmt_clock,
   input wire logic port1_mgmt_data_in,
   output logic port1_mgmt_data_out,
   output logic port1_mgmt_data_oe
);
   emp_mgmt_state_type state_reg, state_next;
   logic [7:0] div_reg;
   logic [6:0] bits_reg, drive_reg;
   logic [FRAME_BITS-1:0] shift_reg, read_reg;
   logic mdc_reg, out_reg, oe_reg, done_reg, din_s1, din_s2;

   wire phase_end = div_reg == 8'(HALF_CYC - 1);
   wire last_bit = bits_reg == 7'(FRAME_BITS - 1);
   wire rise = state_reg == EMP_MGMT_LOW && state_next == EMP_MGMT_HIGH;
   wire fall = state_reg == EMP_MGMT_HIGH && state_next == EMP_MGMT_LOW;
   wire [6:0] bits_inc = 7'(bits_reg + 7'h01);

   // ==========================================================
   // Bit sequencer
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         EMP_MGMT_IDLE: if (mgmt_start) state_next = EMP_MGMT_LOW;
         EMP_MGMT_LOW: if (phase_end) state_next = EMP_MGMT_HIGH;
         EMP_MGMT_HIGH: if (phase_end) state_next = last_bit ? EMP_MGMT_IDLE : EMP_MGMT_LOW;
         default: state_next = EMP_MGMT_IDLE;
      endcase
   end

   always_ff @(posedge clk_sys) begin
      {din_s2, din_s1} <= {din_s1, port1_mgmt_data_in};
      if (rst) begin
         state_reg <= EMP_MGMT_IDLE;
         div_reg <= 8'h00;
         bits_reg <= 7'h00;
         drive_reg <= 7'h00;
         shift_reg <= '0;
         read_reg <= '0;
         mdc_reg <= 1'h0;
         out_reg <= 1'h0;
         oe_reg <= 1'h0;
         done_reg <= 1'h0;
      end else begin
         state_reg <= state_next;
         div_reg <= (state_reg != state_next) ? 8'h00 : 8'(div_reg + 8'h01);
         mdc_reg <= state_next == EMP_MGMT_HIGH;
         done_reg <= state_reg == EMP_MGMT_HIGH && state_next == EMP_MGMT_IDLE;
         if (state_reg == EMP_MGMT_IDLE && mgmt_start) begin
            shift_reg <= mgmt_frame;
            out_reg <= mgmt_frame[FRAME_BITS-1];
            bits_reg <= 7'h00;
            drive_reg <= mgmt_drive_bits;
            oe_reg <= mgmt_drive_bits != 7'h00;
         end
         // The input is two cycles old at the rising edge, which still lies
         // inside the window the PHY holds data after the previous edge.
         if (rise) read_reg <= {read_reg[FRAME_BITS-2:0], din_s2};
         if (fall) begin
            shift_reg <= {shift_reg[FRAME_BITS-2:0], 1'h0};
            out_reg <= shift_reg[FRAME_BITS-2];
            bits_reg <= bits_inc;
            oe_reg <= bits_inc < drive_reg;
         end
         if (state_next == EMP_MGMT_IDLE && state_reg == EMP_MGMT_HIGH) begin
            out_reg <= 1'h0;
            oe_reg <= 1'h0;
         end
      end
   end

   assign mgmt_busy = state_reg != EMP_MGMT_IDLE;
   assign mgmt_done = done_reg;
   assign mgmt_read_word = read_reg;
   assign port1_mgmt_clock = mdc_reg;
   assign port1_mgmt_data_out = out_reg;
   assign port1_mgmt_data_oe = oe_reg;

   // ==========================================================
   // Checks
   mgmt_edge_a: assert property (@(posedge clk_sys) disable iff (rst)
      $changed(out_reg) |-> !mdc_reg) else $error("mgmt data moved while clock high");
   mgmt_sample_a: assert property (@(posedge clk_sys) disable iff (rst)
      rise |=> read_reg[0] == $past(din_s2)) else $error("mgmt bit not sampled at rise");
   mgmt_oe_a: assert property (@(posedge clk_sys) disable iff (rst)
      oe_reg |-> state_reg != EMP_MGMT_IDLE) else $error("mgmt data driven while idle");
   mgmt_done_c: cover property (@(posedge clk_sys) disable iff (rst) done_reg);
endmodule

// ---- core/emp_port.sv ----
// MII / RMII pin interface of the second Ethernet port, MAC side.
// Assumes the system clock is several times faster than the byte rate.
module emp_port
   import emp_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic rmii_mode_sel,
   input wire logic [7:0] tx_byte_data,
   input wire logic tx_byte_last,
   input wire logic tx_byte_valid,
   output logic tx_byte_ready,
   output logic tx_underrun,
   output logic [7:0] rx_byte_data,
   output logic rx_byte_valid,
   output logic rx_byte_last,
   output logic rx_crc_error,
   output logic rx_align_error,
   output logic collision_status,
   output logic carrier_status,
   input wire logic mgmt_start,
   input wire logic [EMP_MGMT_FRAME_BITS-1:0] mgmt_frame,
   input wire logic [6:0] mgmt_drive_bits,
   output logic mgmt_busy,
   output logic mgmt_done,
   output logic [EMP_MGMT_FRAME_BITS-1:0] mgmt_read_word,
   input wire logic port1_transmit_clock,
   input wire logic port1_receive_clock,
   output logic [3:0] port1_transmit_nibble,
   output logic port1_transmit_enable,
   input wire logic [3:0] port1_receive_nibble,
   input wire logic port1_receive_valid,
   input wire logic port1_receive_error,
   input wire logic port1_collision_in,
   input wire logic port1_carrier_sense_in,
   output logic port1_mgmt_clock,
   input wire logic port1_mgmt_data_in,
   output logic port1_mgmt_data_out,
   output logic port1_mgmt_data_oe
);
   function automatic logic [3:0] emp_unit(input logic rmii, input logic [7:0] b);
      return rmii ? {2'h0, b[1:0]} : b[3:0];
   endfunction

   function automatic logic [2:0] emp_units(input logic rmii);
      return rmii ? EMP_RMII_UNITS : EMP_MII_UNITS;
   endfunction

   // ==========================================================
   // Clocking
   // The strap is static, so switching the transmit clock source never
   // happens while the port runs; in RMII the transmit clock pin is unused.
   wire tx_link_clk = rmii_mode_sel ? port1_receive_clock : port1_transmit_clock;

   logic mode_s1, mode_s2, tmode_s1, tmode_s2, rmode_s1, rmode_s2;
   logic trst_s1, trst_s2, rrst_s1, rrst_s2;

   always_ff @(posedge clk_sys) {mode_s2, mode_s1} <= {mode_s1, rmii_mode_sel};
   always_ff @(posedge tx_link_clk) begin
      {tmode_s2, tmode_s1} <= {tmode_s1, rmii_mode_sel};
      {trst_s2, trst_s1} <= {trst_s1, rst};
   end
   always_ff @(posedge port1_receive_clock) begin
      {rmode_s2, rmode_s1} <= {rmode_s1, rmii_mode_sel};
      {rrst_s2, rrst_s1} <= {rrst_s1, rst};
   end

   // ==========================================================
   // Transmit, system side
   logic [7:0] tx_data_reg;
   logic tx_last_reg, tx_req_reg, ack_s1, ack_s2, und_s1, und_s2, und_s3, und_reg;
   logic seen_reg, und_tgl_reg;

   assign tx_byte_ready = ack_s2 == tx_req_reg;
   wire tx_take = tx_byte_valid && tx_byte_ready;

   always_ff @(posedge clk_sys) begin
      {ack_s2, ack_s1} <= {ack_s1, seen_reg};
      {und_s3, und_s2, und_s1} <= {und_s2, und_s1, und_tgl_reg};
      if (rst) begin
         tx_data_reg <= EMP_BYTE_RESET;
         tx_last_reg <= 1'h0;
         tx_req_reg <= 1'h0;
         und_reg <= 1'h0;
      end else begin
         und_reg <= und_s2 ^ und_s3;
         if (tx_take) begin
            tx_data_reg <= tx_byte_data;
            tx_last_reg <= tx_byte_last;
            tx_req_reg <= ~tx_req_reg;
         end
      end
   end
   assign tx_underrun = und_reg;

   // ==========================================================
   // Transmit, link side
   logic req_s1, req_s2, tframe_reg, ten_reg;
   logic [2:0] tcnt_reg;
   logic [7:0] tsh_reg;
   logic [3:0] tnib_reg;

   wire tx_pending = req_s2 != seen_reg;
   wire tx_load = tcnt_reg == 3'h0 && tx_pending;
   wire [7:0] tsh_next = tmode_s2 ? {2'h0, tsh_reg[7:2]} : {4'h0, tsh_reg[7:4]};
   wire [7:0] tload_next = tmode_s2 ? {2'h0, tx_data_reg[7:2]} : {4'h0, tx_data_reg[7:4]};

   always_ff @(posedge tx_link_clk) begin
      if (trst_s2) begin
         {req_s2, req_s1} <= 2'h0;
         seen_reg <= 1'h0;
         und_tgl_reg <= 1'h0;
         tframe_reg <= 1'h0;
         ten_reg <= 1'h0;
         tcnt_reg <= 3'h0;
         tsh_reg <= EMP_BYTE_RESET;
         tnib_reg <= EMP_NIBBLE_IDLE;
      end else begin
         {req_s2, req_s1} <= {req_s1, tx_req_reg};
         if (tcnt_reg != 3'h0) begin
            tnib_reg <= emp_unit(tmode_s2, tsh_reg);
            tsh_reg <= tsh_next;
            tcnt_reg <= 3'(tcnt_reg - 3'h1);
            ten_reg <= 1'h1;
         end else if (tx_pending) begin
            tnib_reg <= emp_unit(tmode_s2, tx_data_reg);
            tsh_reg <= tload_next;
            tcnt_reg <= 3'(emp_units(tmode_s2) - 3'h1);
            seen_reg <= req_s2;
            tframe_reg <= !tx_last_reg;
            ten_reg <= 1'h1;
         end else begin
            tnib_reg <= EMP_NIBBLE_IDLE;
            ten_reg <= 1'h0;
            // A frame cut short by a late byte is ended, not stretched.
            if (tframe_reg) begin
               tframe_reg <= 1'h0;
               und_tgl_reg <= ~und_tgl_reg;
            end
         end
      end
   end
   assign port1_transmit_nibble = tnib_reg;
   assign port1_transmit_enable = ten_reg;

   // ==========================================================
   // Receive, link side
   logic [3:0] rxd_q;
   logic dv_q, err_q, rframe_reg, rhave_reg, rerr_reg, rtgl_reg;
   logic [2:0] rcnt_reg;
   logic [7:0] racc_reg, rpend_reg;
   logic [10:0] rword_reg;

   wire [7:0] racc_in = rmode_s2 ? {rxd_q[1:0], racc_reg[7:2]} : {rxd_q, racc_reg[7:4]};
   wire rx_full = rcnt_reg == 3'(emp_units(rmode_s2) - 3'h1);
   wire rx_end = !dv_q && rframe_reg;

   always_ff @(posedge port1_receive_clock) begin
      if (rrst_s2) begin
         rxd_q <= EMP_NIBBLE_IDLE;
         {dv_q, err_q, rframe_reg, rhave_reg, rerr_reg, rtgl_reg} <= 6'h00;
         rcnt_reg <= 3'h0;
         racc_reg <= EMP_BYTE_RESET;
         rpend_reg <= EMP_BYTE_RESET;
         rword_reg <= 11'h000;
      end else begin
         rxd_q <= port1_receive_nibble;
         dv_q <= port1_receive_valid;
         err_q <= port1_receive_error;
         if (dv_q) begin
            racc_reg <= racc_in;
            rframe_reg <= 1'h1;
            rerr_reg <= rerr_reg | err_q;
            if (rx_full) begin
               rcnt_reg <= 3'h0;
               rpend_reg <= racc_in;
               rhave_reg <= 1'h1;
               if (rhave_reg) begin
                  rword_reg <= {3'h0, rpend_reg};
                  rtgl_reg <= ~rtgl_reg;
               end
            end else begin
               rcnt_reg <= 3'(rcnt_reg + 3'h1);
            end
         end else if (rframe_reg) begin
            // A trailing whole nibble is dropped quietly; a lone di-bit is not.
            rword_reg <= {1'h1, rerr_reg | err_q, rmode_s2 & rcnt_reg[0], rpend_reg};
            rtgl_reg <= ~rtgl_reg;
            {rframe_reg, rhave_reg, rerr_reg} <= 3'h0;
            rcnt_reg <= 3'h0;
            rpend_reg <= EMP_BYTE_RESET;
         end
      end
   end

   // ==========================================================
   // Receive and status, system side
   logic rt_s1, rt_s2, rt_s3, col_s1, col_s2, crs_s1, crs_s2;
   logic [7:0] rx_data_reg;
   logic rx_valid_reg, rx_last_reg, rx_crc_reg, rx_align_reg, col_reg, crs_reg;

   // The hand-over word is read directly: it holds for a byte time, but a frame end on a byte boundary replaces it one receive clock later.
   wire rx_evt = rt_s2 ^ rt_s3;

   always_ff @(posedge clk_sys) begin
      {rt_s3, rt_s2, rt_s1} <= {rt_s2, rt_s1, rtgl_reg};
      {col_s2, col_s1} <= {col_s1, port1_collision_in};
      {crs_s2, crs_s1} <= {crs_s1, port1_carrier_sense_in};
      if (rst) begin
         rx_data_reg <= EMP_BYTE_RESET;
         {rx_valid_reg, rx_last_reg, rx_crc_reg, rx_align_reg} <= 4'h0;
         {col_reg, crs_reg} <= 2'h0;
      end else begin
         rx_valid_reg <= rx_evt;
         if (rx_evt) begin
            rx_data_reg <= rword_reg[7:0];
            rx_last_reg <= rword_reg[EMP_RXW_LAST];
            rx_crc_reg <= rword_reg[EMP_RXW_CRC];
            rx_align_reg <= rword_reg[EMP_RXW_ALIGN];
         end
         col_reg <= !mode_s2 && col_s2;
         crs_reg <= !mode_s2 && crs_s2;
      end
   end
   assign rx_byte_data = rx_data_reg;
   assign rx_byte_valid = rx_valid_reg;
   assign rx_byte_last = rx_last_reg;
   assign rx_crc_error = rx_crc_reg;
   assign rx_align_error = rx_align_reg;
   assign collision_status = col_reg;
   assign carrier_status = crs_reg;

   // ==========================================================
   // Management
   emp_mgmt u_mgmt (
      .clk_sys(clk_sys),
      .rst(rst),
      .mgmt_start(mgmt_start),
      .mgmt_frame(mgmt_frame),
      .mgmt_drive_bits(mgmt_drive_bits),
      .mgmt_busy(mgmt_busy),
      .mgmt_done(mgmt_done),
      .mgmt_read_word(mgmt_read_word),
      .port1_mgmt_clock(port1_mgmt_clock),
      .port1_mgmt_data_in(port1_mgmt_data_in),
      .port1_mgmt_data_out(port1_mgmt_data_out),
      .port1_mgmt_data_oe(port1_mgmt_data_oe)
   );

   // ==========================================================
   // Checks
   tx_upper_a: assert property (@(posedge tx_link_clk) disable iff (trst_s2)
      tmode_s2 |=> tnib_reg[3:2] == 2'h0) else $error("RMII upper lines driven");
   tx_first_a: assert property (@(posedge tx_link_clk) disable iff (trst_s2)
      tx_load |=> ten_reg && tnib_reg == emp_unit($past(tmode_s2), $past(tx_data_reg)))
      else $error("enable not with first unit");
   tx_hold_a: assert property (@(posedge tx_link_clk) disable iff (trst_s2)
      tcnt_reg != 3'h0 |=> ten_reg) else $error("enable dropped inside byte");
   tx_idle_a: assert property (@(posedge tx_link_clk) disable iff (trst_s2)
      tcnt_reg == 3'h0 && !tx_pending |=> !ten_reg && tnib_reg == EMP_NIBBLE_IDLE)
      else $error("data driven with no byte");
   rx_mii_a: assert property (@(posedge port1_receive_clock) disable iff (rrst_s2)
      dv_q && !rmode_s2 |=> racc_reg[7:4] == $past(rxd_q)) else $error("nibble not taken");
   rx_rmii_a: assert property (@(posedge port1_receive_clock) disable iff (rrst_s2)
      dv_q && rmode_s2 |=> racc_reg[7:6] == $past(rxd_q[1:0])) else $error("di-bit not taken");
   rx_hold_a: assert property (@(posedge port1_receive_clock) disable iff (rrst_s2)
      !dv_q |=> $stable(racc_reg)) else $error("data taken without valid");
   rx_crc_a: assert property (@(posedge port1_receive_clock) disable iff (rrst_s2)
      rx_end && (rerr_reg || err_q) |=> rword_reg[EMP_RXW_CRC] && rword_reg[EMP_RXW_LAST])
      else $error("receive error not reported");
   rx_align_a: assert property (@(posedge port1_receive_clock) disable iff (rrst_s2)
      rx_end |=> rword_reg[EMP_RXW_ALIGN] == $past(rmode_s2 && rcnt_reg[0]))
      else $error("frame end boundary misjudged");
   status_ignore_a: assert property (@(posedge clk_sys) disable iff (rst)
      mode_s2 |=> !collision_status && !carrier_status) else $error("RMII status not ignored");
   tx_frame_c: cover property (@(posedge tx_link_clk) disable iff (trst_s2)
      ten_reg ##1 !ten_reg);
   rx_end_c: cover property (@(posedge port1_receive_clock) disable iff (rrst_s2) rx_end);
   rx_crc_c: cover property (@(posedge clk_sys) disable iff (rst)
      rx_byte_valid && rx_crc_error);
endmodule

// ---- dv/emp_phy_model.sv ----
// Behavioural PHY on the far side of the second Ethernet port.
// Assumes the bench resolves the management wire with a pull-up.
module emp_phy_model
   import emp_pkg::*;
(
   input wire logic rmii_mode,
   output logic phy_tx_clock,
   output logic phy_rx_clock,
   input wire logic [3:0] tx_nibble,
   input wire logic tx_enable,
   output logic [3:0] rx_nibble,
   output logic rx_valid,
   output logic rx_error,
   input wire logic mgmt_clock,
   input wire logic mgmt_wire
);
   timeunit 1ns;
   timeprecision 100ps;

   logic link_clk = 1'b0;
   logic frame_on = 1'b0;
   logic [7:0] tx_acc = 8'h00;
   int tx_units = 0;
   int tx_upper_bad = 0;
   logic [7:0] tx_q[$];
   logic [EMP_MGMT_FRAME_BITS-1:0] mg_cap = '0;
   int mg_cnt = 0;

   // ==========================================================
   // Link clock
   // Ethernet link clocks run free; the phase offset keeps it unrelated to clk_sys.
   initial begin
      #7;
      forever #16 link_clk = ~link_clk;
   end
   assign phy_rx_clock = link_clk;
   assign phy_tx_clock = rmii_mode ? 1'b1 : link_clk;

   // ==========================================================
   // Receive side
   initial begin
      rx_valid = 1'b0;
      rx_error = 1'b0;
      rx_nibble = 4'h0;
   end
   // Released data lines keep changing so stale data is never mistaken for a unit.
   always @(posedge link_clk) begin
      if (!frame_on) begin
         rx_nibble <= rx_nibble + 4'h3;
      end
   end

   // An extra whole nibble after the byte keeps the frame end on a nibble boundary.
   task automatic send_frame(input logic [7:0] b, input logic err, input logic extra);
      int units;
      logic [3:0] u;
      units = rmii_mode ? (extra ? 6 : 4) : (extra ? 3 : 2);
      frame_on = 1'b1;
      for (int i = 0; i < units; i++) begin
         @(posedge link_clk);
         u = rmii_mode ? {2'($urandom), b[2*(i%4) +: 2]} : b[4*(i%2) +: 4];
         rx_nibble <= u;
         rx_valid <= 1'b1;
         rx_error <= err;
      end
      @(posedge link_clk);
      rx_valid <= 1'b0;
      rx_error <= 1'b0;
      frame_on = 1'b0;
   endtask

   // ==========================================================
   // Transmit capture, low unit first, only while enable is high
   always @(posedge link_clk) begin
      if (tx_enable === 1'b1) begin
         if (rmii_mode && tx_nibble[3:2] !== 2'b00) begin
            tx_upper_bad++;
         end
         tx_acc = rmii_mode ? {tx_nibble[1:0], tx_acc[7:2]} : {tx_nibble, tx_acc[7:4]};
         tx_units++;
         if (tx_units == (rmii_mode ? 4 : 2)) begin
            tx_q.push_back(tx_acc);
            tx_units = 0;
         end
      end else begin
         tx_units = 0;
      end
   end

   // ==========================================================
   // Management listener samples on the rising clock edge
   always @(posedge mgmt_clock) begin
      mg_cap <= {mg_cap[EMP_MGMT_FRAME_BITS-2:0], mgmt_wire};
      mg_cnt <= mg_cnt + 1;
   end
endmodule

// ---- dv/emp_port_tb_top.sv ----
// Self-checking bench of the second Ethernet port pin interface.
// Assumes the PHY model above; single-byte frames keep within the link rate.
module emp_port_tb_top
   import emp_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;

   logic clk_sys = 1'b0;
   logic rst = 1'b1;
   logic rmii_mode_sel = 1'b0;
   logic [7:0] tx_byte_data = 8'h00;
   logic tx_byte_last = 1'b0;
   logic tx_byte_valid = 1'b0;
   logic mgmt_start = 1'b0;
   logic [EMP_MGMT_FRAME_BITS-1:0] mgmt_frame = '0;
   logic [6:0] mgmt_drive_bits = 7'h00;
   logic port1_collision_in = 1'b0;
   logic port1_carrier_sense_in = 1'b0;
   logic tx_byte_ready, tx_underrun, rx_byte_valid, rx_byte_last, rx_crc_error;
   logic rx_align_error, collision_status, carrier_status, mgmt_busy, mgmt_done;
   logic [7:0] rx_byte_data;
   logic [EMP_MGMT_FRAME_BITS-1:0] mgmt_read_word;
   logic port1_transmit_clock, port1_receive_clock, port1_transmit_enable;
   logic [3:0] port1_transmit_nibble, port1_receive_nibble;
   logic port1_receive_valid, port1_receive_error, port1_mgmt_clock;
   logic port1_mgmt_data_out, port1_mgmt_data_oe, mdio_wire;
   logic [10:0] rx_q[$];
   int und_count = 0;
   int errors = 0;
   int cmp_count = 0;
   int cycles = 0;

   always #25 clk_sys = ~clk_sys;
   assign mdio_wire = port1_mgmt_data_oe ? port1_mgmt_data_out : 1'b1;

   emp_port u_dut (.clk_sys(clk_sys), .rst(rst), .rmii_mode_sel(rmii_mode_sel),
      .tx_byte_data(tx_byte_data), .tx_byte_last(tx_byte_last),
      .tx_byte_valid(tx_byte_valid), .tx_byte_ready(tx_byte_ready),
      .tx_underrun(tx_underrun), .rx_byte_data(rx_byte_data),
      .rx_byte_valid(rx_byte_valid), .rx_byte_last(rx_byte_last),
      .rx_crc_error(rx_crc_error), .rx_align_error(rx_align_error),
      .collision_status(collision_status), .carrier_status(carrier_status),
      .mgmt_start(mgmt_start), .mgmt_frame(mgmt_frame),
      .mgmt_drive_bits(mgmt_drive_bits), .mgmt_busy(mgmt_busy),
      .mgmt_done(mgmt_done), .mgmt_read_word(mgmt_read_word),
      .port1_transmit_clock(port1_transmit_clock),
      .port1_receive_clock(port1_receive_clock),
      .port1_transmit_nibble(port1_transmit_nibble),
      .port1_transmit_enable(port1_transmit_enable),
      .port1_receive_nibble(port1_receive_nibble),
      .port1_receive_valid(port1_receive_valid),
      .port1_receive_error(port1_receive_error),
      .port1_collision_in(port1_collision_in),
      .port1_carrier_sense_in(port1_carrier_sense_in),
      .port1_mgmt_clock(port1_mgmt_clock), .port1_mgmt_data_in(mdio_wire),
      .port1_mgmt_data_out(port1_mgmt_data_out), .port1_mgmt_data_oe(port1_mgmt_data_oe));

   emp_phy_model u_phy (.rmii_mode(rmii_mode_sel), .phy_tx_clock(port1_transmit_clock),
      .phy_rx_clock(port1_receive_clock), .tx_nibble(port1_transmit_nibble),
      .tx_enable(port1_transmit_enable), .rx_nibble(port1_receive_nibble),
      .rx_valid(port1_receive_valid), .rx_error(port1_receive_error),
      .mgmt_clock(port1_mgmt_clock), .mgmt_wire(mdio_wire));

   // ==========================================================
   // Reporting
   task automatic check(input logic [63:0] seen, input logic [63:0] expected, input string what);
      cmp_count++;
      if (seen !== expected) begin
         errors++;
         $display("MISMATCH at %0t: %s seen %h expected %h", $time, what, seen, expected);
      end
   endtask

   task automatic complete_run;
      $display("Comparisons %0d, mismatches %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask

   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 40000) begin
         errors++;
         complete_run();
      end
      if (rx_byte_valid === 1'b1) begin
         rx_q.push_back({rx_align_error, rx_byte_last, rx_crc_error, rx_byte_data});
      end
      if (tx_underrun === 1'b1) begin
         und_count++;
      end
   end

   // ==========================================================
   // Scenarios
   task automatic do_reset(input logic mode);
      rst <= 1'b1;
      @(posedge clk_sys);
      rmii_mode_sel <= mode;
      repeat (11) @(posedge clk_sys);
      rst <= 1'b0;
      // The link side leaves reset a few link clocks after clk_sys does.
      repeat (12) @(posedge clk_sys);
   endtask

   // Bits past the driven count read back as the pull-up level.
   function automatic logic [63:0] exp_mgmt(input logic [63:0] frame, input logic [6:0] drive);
      logic [63:0] w;
      for (int i = 0; i < 64; i++) w[63-i] = (i < drive) ? frame[63-i] : 1'b1;
      return w;
   endfunction

   task automatic rx_frame(input logic [7:0] b, input logic err, input logic extra);
      int n;
      logic [10:0] ev;
      u_phy.send_frame(b, err, extra);
      n = 0;
      while (rx_q.size() == 0 && n < 60) begin
         @(posedge clk_sys);
         n++;
      end
      repeat (8) @(posedge clk_sys);
      check(rx_q.size(), 1, "rx event count");
      if (rx_q.size() > 0) ev = rx_q.pop_front();
      else ev = '1;
      check(ev, {1'b0, 1'b1, err, b}, "rx last event");
      rx_q.delete();
   endtask

   task automatic tx_frame(input logic [7:0] b, input logic last);
      int n;
      int u0;
      logic [7:0] v;
      n = 0;
      u0 = und_count;
      tx_byte_data <= b;
      tx_byte_last <= last;
      tx_byte_valid <= 1'b1;
      do begin
         @(posedge clk_sys);
         n++;
      end while (tx_byte_ready !== 1'b1 && n < 200);
      tx_byte_valid <= 1'b0;
      n = 0;
      while (u_phy.tx_q.size() == 0 && n < 80) begin
         @(posedge clk_sys);
         n++;
      end
      repeat (8) @(posedge clk_sys);
      check(u_phy.tx_q.size(), 1, "tx byte count");
      check(und_count - u0, !last, "tx underrun");
      if (u_phy.tx_q.size() > 0) v = u_phy.tx_q.pop_front();
      else v = ~b;
      check(v, b, "tx byte");
      check(port1_transmit_enable, 1'b0, "tx enable idle");
      u_phy.tx_q.delete();
   endtask

   task automatic status_run(input logic mode);
      for (int v = 1; v >= 0; v--) begin
         port1_collision_in <= v[0];
         port1_carrier_sense_in <= v[0];
         repeat (8) @(posedge clk_sys);
         check(collision_status, v[0] & ~mode, "collision status");
         check(carrier_status, v[0] & ~mode, "carrier status");
      end
   endtask

   task automatic mgmt_run(input logic [6:0] drive);
      logic [63:0] frame;
      logic [63:0] expw;
      int n;
      int c0;
      frame = {$urandom, $urandom};
      expw = exp_mgmt(frame, drive);
      c0 = u_phy.mg_cnt;
      mgmt_frame <= frame;
      mgmt_drive_bits <= drive;
      mgmt_start <= 1'b1;
      @(posedge clk_sys);
      mgmt_start <= 1'b0;
      @(posedge clk_sys);
      check(mgmt_busy, 1'b1, "mgmt busy");
      n = 0;
      while (mgmt_done !== 1'b1 && n < 700) begin
         @(posedge clk_sys);
         n++;
      end
      check(mgmt_done, 1'b1, "mgmt done");
      repeat (2) @(posedge clk_sys);
      check(u_phy.mg_cnt - c0, 64, "mgmt clock rises");
      check(mgmt_busy, 1'b0, "mgmt idle");
      check(u_phy.mg_cap, expw, "mgmt bits at phy");
      check(mgmt_read_word, expw, "mgmt read word");
   endtask

   initial begin
      void'($urandom(44540));
      for (int m = 0; m < 2; m++) begin
         do_reset(m[0]);
         rx_frame(8'h00, 1'b0, 1'b0);
         rx_frame(8'hff, 1'b1, 1'b1);
         for (int k = 0; k < 6; k++) rx_frame(8'($urandom), 1'($urandom), 1'($urandom));
         tx_frame(8'h00, 1'b1);
         tx_frame(8'hff, 1'b0);
         for (int k = 0; k < 6; k++) tx_frame(8'($urandom), 1'($urandom));
         status_run(m[0]);
         mgmt_run(7'h00);
         mgmt_run(7'h40);
         mgmt_run(7'($urandom_range(63, 1)));
      end
      check(u_phy.tx_upper_bad, 0, "rmii upper lines");
      complete_run();
   end
endmodule
